// ==== cfs_sequencer.sv ====
// Supervisory sequencer of a switching converter: switch timing, overcurrent,
// hiccup, prebiased start, thermal shutdown and open-drain power-good.
// Assumes every comparator flag and the oscillator arrive as asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
`include "cfs_consts.svh"
module cfs_sequencer #(
    parameter int HICCUP_CYCLES = `CFS_HICCUP_CYCLES,
    parameter int SS_EXTRA_CYCLES = `CFS_SS_EXTRA_CYCLES,
    parameter int PGOOD_DELAY_CYCLES = `CFS_PGOOD_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Oscillator and supply
    input wire logic osc_clk_in,
    input wire logic enable_lockout_input,
    input wire logic vcc_undervoltage,
    // Current comparators
    input wire logic cycle_current_limit,
    input wire logic severe_overcurrent_limit,
    input wire logic pwm_peak_reached,
    input wire logic zero_current_detect,
    // Voltage comparators
    input wire logic feedback_below_hiccup,
    input wire logic soft_start_above_feedback,
    input wire logic soft_start_done,
    input wire logic output_above_95,
    input wire logic output_below_92,
    // Thermal sensor
    input wire logic thermal_overtemp,
    input wire logic thermal_cooled,
    // Mode strap
    input wire logic light_load_skip_mode,
    // Gate controls
    output logic high_side_gate,
    output logic low_side_gate,
    output logic soft_start_enable,
    // Open-drain power-good
    output logic power_good_out,
    output logic power_good_oe,
    // Status
    output logic hiccup_active,
    output logic half_freq_active,
    output logic thermal_shutdown
);
    localparam int HW = $clog2(HICCUP_CYCLES + 1);
    localparam int EW = $clog2(SS_EXTRA_CYCLES + 1);
    localparam int PW = $clog2(PGOOD_DELAY_CYCLES + 1);
    localparam logic [5:0] MIN_ON = 6'(`CFS_MIN_ON_CYC);
    localparam logic [5:0] MIN_OFF = 6'(`CFS_MIN_OFF_CYC);
    localparam logic [5:0] CNT_SAT = 6'h3f;
    localparam logic [HW-1:0] HIC_LAST = HW'(HICCUP_CYCLES - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(SS_EXTRA_CYCLES - 1);
    localparam logic [PW-1:0] PG_LAST = PW'(PGOOD_DELAY_CYCLES - 1);

    // ********************************
    // Input synchronisation
    // ********************************
    logic [`CFS_IN_WIDTH-1:0] s;

    cfs_sync #(.WIDTH(`CFS_IN_WIDTH)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({light_load_skip_mode, zero_current_detect, thermal_cooled, thermal_overtemp,
                   output_below_92, output_above_95, soft_start_done, soft_start_above_feedback,
                   feedback_below_hiccup, pwm_peak_reached, severe_overcurrent_limit,
                   cycle_current_limit, vcc_undervoltage, enable_lockout_input, osc_clk_in}),
        .sync_out(s)
    );

    logic disabled;
    logic severe;
    logic fb_low;
    assign disabled = ~s[`CFS_IN_ENABLE] | s[`CFS_IN_VCC_UV];
    assign severe = s[`CFS_IN_SEVERE];
    assign fb_low = s[`CFS_IN_FEEDBACK_LOW];

    // ********************************
    // Oscillator edge and half-rate phase
    // ********************************
    logic osc_d_reg;
    logic osc_d_next;
    logic phase_reg;
    logic phase_next;
    logic osc_rise;
    logic half_tick;

    // Phase flips so the half-rate tick comes every second edge
    always_comb begin
        osc_d_next = s[`CFS_IN_OSC];
        phase_next = phase_reg ^ osc_rise;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_d_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            osc_d_reg <= osc_d_next;
            phase_reg <= phase_next;
        end
    end

    assign osc_rise = s[`CFS_IN_OSC] & ~osc_d_reg;
    assign half_tick = osc_rise & phase_reg;

    // ********************************
    // Sequence state
    // ********************************
    cfs_pkg::cfs_state_t state_reg;
    cfs_pkg::cfs_state_t state_next;
    logic [HW-1:0] hic_cnt_reg;
    logic [HW-1:0] hic_cnt_next;
    logic [EW-1:0] ext_cnt_reg;
    logic [EW-1:0] ext_cnt_next;
    logic fb_ok_reg;
    logic fb_ok_next;

    // Disable beats thermal, thermal beats the normal sequence
    always_comb begin
        state_next = state_reg;
        hic_cnt_next = hic_cnt_reg;
        ext_cnt_next = ext_cnt_reg;
        fb_ok_next = fb_ok_reg;
        if (disabled) begin
            state_next = cfs_pkg::CFS_OFF;
            hic_cnt_next = '0;
            ext_cnt_next = '0;
            fb_ok_next = 1'b0;
        end else if (s[`CFS_IN_THERM_HOT] && state_reg != cfs_pkg::CFS_THERMAL) begin
            state_next = cfs_pkg::CFS_THERMAL;
        end else begin
            case (state_reg)
                cfs_pkg::CFS_OFF: begin
                    state_next = cfs_pkg::CFS_PREBIAS;
                    fb_ok_next = 1'b0;
                    ext_cnt_next = '0;
                end
                cfs_pkg::CFS_PREBIAS: begin
                    if (s[`CFS_IN_SS_CROSSED]) begin
                        state_next = cfs_pkg::CFS_RUN;
                    end
                end
                cfs_pkg::CFS_RUN: begin
                    if (!fb_low) begin
                        fb_ok_next = 1'b1;
                    end
                    if (severe) begin
                        state_next = cfs_pkg::CFS_HICCUP;
                        hic_cnt_next = '0;
                    end else if (s[`CFS_IN_SS_DONE] && fb_ok_reg && fb_low) begin
                        state_next = cfs_pkg::CFS_HICCUP;
                        hic_cnt_next = '0;
                    end else if (s[`CFS_IN_SS_DONE] && !fb_ok_reg && fb_low && half_tick) begin
                        // Feedback never made it: grant the extra cycles, then give up
                        if (ext_cnt_reg == EXT_LAST) begin
                            state_next = cfs_pkg::CFS_HICCUP;
                            hic_cnt_next = '0;
                        end else begin
                            ext_cnt_next = ext_cnt_reg + 1'b1;
                        end
                    end
                end
                cfs_pkg::CFS_HICCUP: begin
                    if (half_tick) begin
                        if (hic_cnt_reg == HIC_LAST) begin
                            state_next = cfs_pkg::CFS_PREBIAS;
                            fb_ok_next = 1'b0;
                            ext_cnt_next = '0;
                        end else begin
                            hic_cnt_next = hic_cnt_reg + 1'b1;
                        end
                    end
                end
                cfs_pkg::CFS_THERMAL: begin
                    if (s[`CFS_IN_THERM_COOLED] && !s[`CFS_IN_THERM_HOT]) begin
                        state_next = cfs_pkg::CFS_PREBIAS;
                        fb_ok_next = 1'b0;
                        ext_cnt_next = '0;
                        hic_cnt_next = '0;
                    end
                end
                default: begin
                    state_next = cfs_pkg::CFS_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= cfs_pkg::CFS_OFF;
            hic_cnt_reg <= '0;
            ext_cnt_reg <= '0;
            fb_ok_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hic_cnt_reg <= hic_cnt_next;
            ext_cnt_reg <= ext_cnt_next;
            fb_ok_reg <= fb_ok_next;
        end
    end

    // ********************************
    // Switch timing
    // ********************************
    logic hs_reg;
    logic hs_next;
    logic ls_reg;
    logic ls_next;
    logic pend_reg;
    logic pend_next;
    logic ls_block_reg;
    logic ls_block_next;
    logic [5:0] on_cnt_reg;
    logic [5:0] on_cnt_next;
    logic [5:0] off_cnt_reg;
    logic [5:0] off_cnt_next;
    logic switching;
    logic half_mode;
    logic hs_on;
    logic hs_off;

    // Next state gates too, so gates drop on the edge that leaves run
    assign switching = (state_reg == cfs_pkg::CFS_RUN) && (state_next == cfs_pkg::CFS_RUN);
    assign half_mode = ~fb_ok_reg;
    // Turn-on waits out the off time and a dead-time cycle
    assign hs_on = switching && pend_reg && !hs_reg && !ls_reg && (off_cnt_reg >= MIN_OFF);
    // Protective stops skip the on-time floor; normal ends respect it
    assign hs_off = hs_reg && (!switching || ((on_cnt_reg >= MIN_ON) &&
                    (s[`CFS_IN_PWM_TRIP] || s[`CFS_IN_PEAK] || osc_rise)));

    always_comb begin
        pend_next = pend_reg;
        if (!switching || hs_on) begin
            pend_next = 1'b0;
        end else if (osc_rise && (!half_mode || phase_reg)) begin
            pend_next = 1'b1;
        end
        hs_next = hs_on ? 1'b1 : (hs_off ? 1'b0 : hs_reg);
        on_cnt_next = hs_on ? 6'h00 : ((hs_reg && on_cnt_reg != CNT_SAT) ? on_cnt_reg + 6'h01 : on_cnt_reg);
        off_cnt_next = hs_off ? 6'h00 : ((!hs_reg && off_cnt_reg != CNT_SAT) ? off_cnt_reg + 6'h01 : off_cnt_reg);
        ls_block_next = ls_block_reg;
        if (hs_on) begin
            ls_block_next = 1'b0;
        end else if (s[`CFS_IN_LIGHT_LOAD] && s[`CFS_IN_ZERO_CURRENT] && !hs_reg) begin
            ls_block_next = 1'b1;
        end
        ls_next = switching && !hs_reg && !hs_next && !pend_next && !ls_block_next;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
            pend_reg <= 1'b0;
            ls_block_reg <= 1'b0;
            on_cnt_reg <= 6'h00;
            off_cnt_reg <= 6'h00;
        end else begin
            hs_reg <= hs_next;
            ls_reg <= ls_next;
            pend_reg <= pend_next;
            ls_block_reg <= ls_block_next;
            on_cnt_reg <= on_cnt_next;
            off_cnt_reg <= off_cnt_next;
        end
    end

    // ********************************
    // Power-good
    // ********************************
    logic pg_low_reg;
    logic pg_low_next;
    logic [PW-1:0] pg_cnt_reg;
    logic [PW-1:0] pg_cnt_next;

    // Counts above the rising threshold; holds in the band
    always_comb begin
        pg_low_next = pg_low_reg;
        pg_cnt_next = pg_cnt_reg;
        if (disabled || state_reg == cfs_pkg::CFS_THERMAL || s[`CFS_IN_OUT_BELOW_92]) begin
            pg_low_next = 1'b1;
            pg_cnt_next = '0;
        end else if (pg_low_reg && s[`CFS_IN_OUT_ABOVE_95] && osc_rise) begin
            if (pg_cnt_reg == PG_LAST) begin
                pg_low_next = 1'b0;
            end else begin
                pg_cnt_next = pg_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_low_reg <= `CFS_PGOOD_LOW_RST;
            pg_cnt_reg <= '0;
        end else begin
            pg_low_reg <= pg_low_next;
            pg_cnt_reg <= pg_cnt_next;
        end
    end

    // ********************************
    // Registered outputs
    // ********************************
    logic ss_en_reg;
    logic pg_out_reg;
    logic hic_reg;
    logic half_reg;
    logic therm_reg;

    // Soft-start is released only in prebias wait and run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_en_reg <= 1'b0;
            pg_out_reg <= 1'b0;
            hic_reg <= 1'b0;
            half_reg <= 1'b0;
            therm_reg <= 1'b0;
        end else begin
            ss_en_reg <= (state_next == cfs_pkg::CFS_PREBIAS) || (state_next == cfs_pkg::CFS_RUN);
            pg_out_reg <= 1'b0;
            hic_reg <= state_next == cfs_pkg::CFS_HICCUP;
            half_reg <= (state_next == cfs_pkg::CFS_RUN) && !fb_ok_next;
            therm_reg <= state_next == cfs_pkg::CFS_THERMAL;
        end
    end

    assign high_side_gate = hs_reg;
    assign low_side_gate = ls_reg;
    assign soft_start_enable = ss_en_reg;
    assign power_good_out = pg_out_reg;
    assign power_good_oe = pg_low_reg;
    assign hiccup_active = hic_reg;
    assign half_freq_active = half_reg;
    assign thermal_shutdown = therm_reg;
endmodule
`default_nettype wire

// ==== cfs_consts.svh ====
// Timing counts, reset values and input bit positions of the converter fault sequencer.
// Assumes a 125 MHz system clock; the switching oscillator arrives as a pin.
//
// Behaviour
// - High-side off at least 160 ns per cycle.
// - High-side on at least 80 ns once on; protective stops (hiccup, thermal, disable) end it sooner.
// - Peak limit ends the high-side pulse for the cycle.
// - One severe overcurrent enters hiccup at once.
// - Feedback below hiccup threshold after soft-start enters hiccup.
// - Hiccup stops switching for 32,768 half-rate cycles.
// - Hiccup expiry starts a fresh soft-start.
// - Feedback low in soft-start: half rate for soft-start plus 1024 cycles.
// - Power-good released 1024 cycles after output exceeds 95%.
// - Power-good driven low when output falls below 92%.
// - Power-good low in thermal shutdown or enable below threshold.
// - Prebiased start: switches off until soft-start crosses feedback.
// - Overtemperature shuts down; restart only after cooling.
// - Soft-start off in thermal shutdown; full startup on recovery.
// - Startup at half rate until feedback reaches hiccup threshold.
// - Each cycle turns high-side on at oscillator rising edge.
// - Light-load mode drops low-side before current reverses.
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

// ********************************
// Timing
// ********************************
`define CFS_CLK_PERIOD_NS 8
`define CFS_MIN_OFF_NS 160
`define CFS_MIN_ON_NS 80
// Least times round up to whole clock cycles
`define CFS_MIN_OFF_CYC ((`CFS_MIN_OFF_NS + `CFS_CLK_PERIOD_NS - 1) / `CFS_CLK_PERIOD_NS)
`define CFS_MIN_ON_CYC ((`CFS_MIN_ON_NS + `CFS_CLK_PERIOD_NS - 1) / `CFS_CLK_PERIOD_NS)
`define CFS_HICCUP_CYCLES 32768
`define CFS_SS_EXTRA_CYCLES 1024
`define CFS_PGOOD_DELAY_CYCLES 1024

// ********************************
// Synchronised input bit positions
// ********************************
`define CFS_IN_WIDTH 15
`define CFS_IN_OSC 0
`define CFS_IN_ENABLE 1
`define CFS_IN_VCC_UV 2
`define CFS_IN_PEAK 3
`define CFS_IN_SEVERE 4
`define CFS_IN_PWM_TRIP 5
`define CFS_IN_FEEDBACK_LOW 6
`define CFS_IN_SS_CROSSED 7
`define CFS_IN_SS_DONE 8
`define CFS_IN_OUT_ABOVE_95 9
`define CFS_IN_OUT_BELOW_92 10
`define CFS_IN_THERM_HOT 11
`define CFS_IN_THERM_COOLED 12
`define CFS_IN_ZERO_CURRENT 13
`define CFS_IN_LIGHT_LOAD 14

// ********************************
// Reset values
// ********************************
`define CFS_PGOOD_LOW_RST 1'b1

`endif

// ==== cfs_pkg.sv ====
// Types of the converter fault sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package cfs_pkg;

    // ********************************
    // Sequencer states, Gray coded along startup
    // ********************************
    typedef enum logic [2:0] {
        CFS_OFF = 3'h0,
        CFS_PREBIAS = 3'h1,
        CFS_RUN = 3'h3,
        CFS_HICCUP = 3'h2,
        CFS_THERMAL = 3'h6
    } cfs_state_t;

endpackage

// ==== cfs_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each bit is a level, not a pulse shorter than two clocks.
`timescale 1ns/100ps
`default_nettype none
module cfs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // First stage feeds only the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ==== cfs_monitor.sv ====
// Checker on the fault sequencer ports, with its bind.
// Assumes the oscillator pin repeats every OSC_CYC system clocks.
`timescale 1ns/100ps
`default_nettype none
module cfs_monitor #(
    parameter int HICCUP_CYCLES = 4,
    parameter int PGOOD_DELAY_CYCLES = 4,
    parameter int OSC_CYC = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins in
    input wire logic osc_clk_in,
    input wire logic enable_lockout_input,
    input wire logic vcc_undervoltage,
    input wire logic severe_overcurrent_limit,
    input wire logic soft_start_above_feedback,
    input wire logic zero_current_detect,
    input wire logic light_load_skip_mode,
    input wire logic output_above_95,
    input wire logic output_below_92,
    // Pins out
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic soft_start_enable,
    input wire logic power_good_out,
    input wire logic power_good_oe,
    input wire logic hiccup_active,
    input wire logic thermal_shutdown
);
    // Hiccup window, one tick loose for phase
    localparam int HIC_LO = (HICCUP_CYCLES - 1) * 2 * OSC_CYC;
    localparam int HIC_HI = (HICCUP_CYCLES + 1) * 2 * OSC_CYC + 8;
    logic [7:0] off_cnt_reg, off_cnt_next, on_cnt_reg, on_cnt_next;
    logic [15:0] hic_cnt_reg, hic_cnt_next, pg_cnt_reg, pg_cnt_next;
    logic osc_d_reg;

    // ********************************
    // Helper counters
    // ********************************
    // Raw oscillator rises; sync lag as the qualifiers
    always_comb begin
        off_cnt_next = high_side_gate ? 8'h00 : off_cnt_reg + {7'h00, off_cnt_reg != 8'hff};
        on_cnt_next = !high_side_gate ? 8'h00 : on_cnt_reg + {7'h00, on_cnt_reg != 8'hff};
        hic_cnt_next = hiccup_active ? hic_cnt_reg + 16'h0001 : 16'h0000;
        pg_cnt_next = pg_cnt_reg;
        if (output_below_92 || !enable_lockout_input || thermal_shutdown)
            pg_cnt_next = 16'h0000;
        else if (power_good_oe && output_above_95 && osc_clk_in && !osc_d_reg)
            pg_cnt_next = pg_cnt_reg + 16'h0001;
    end

    // Register the helpers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_reg <= 8'h00;
            on_cnt_reg <= 8'h00;
            hic_cnt_reg <= 16'h0000;
            pg_cnt_reg <= 16'h0000;
            osc_d_reg <= 1'b0;
        end else begin
            off_cnt_reg <= off_cnt_next;
            on_cnt_reg <= on_cnt_next;
            hic_cnt_reg <= hic_cnt_next;
            pg_cnt_reg <= pg_cnt_next;
            osc_d_reg <= osc_clk_in;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_min_off_time: assert property ($rose(high_side_gate) |-> off_cnt_reg >= 8'h14)
        else $error("off time short");
    // Protective shutdowns are exempt from the on-time floor
    a_min_on_time: assert property ($fell(high_side_gate) && !hiccup_active && !thermal_shutdown
        && enable_lockout_input && !vcc_undervoltage |-> on_cnt_reg >= 8'h0a)
        else $error("on time short");
    a_severe_to_hiccup: assert property ($rose(severe_overcurrent_limit) && (high_side_gate || low_side_gate)
        |-> ##[1:4] (hiccup_active && !high_side_gate))
        else $error("no hiccup on severe");
    a_hiccup_quiet: assert property (hiccup_active |-> !high_side_gate && !low_side_gate)
        else $error("switching during hiccup");
    a_hiccup_span: assert property ($fell(hiccup_active) && soft_start_enable
        |-> hic_cnt_reg >= HIC_LO && hic_cnt_reg <= HIC_HI)
        else $error("hiccup length wrong");
    a_pg_delay: assert property ($fell(power_good_oe)
        |-> pg_cnt_reg >= PGOOD_DELAY_CYCLES && pg_cnt_reg <= PGOOD_DELAY_CYCLES + 1)
        else $error("pg delay wrong");
    a_pg_below: assert property ($rose(output_below_92) |-> ##[1:4] power_good_oe)
        else $error("pg not low");
    a_pg_thermal: assert property (thermal_shutdown && $past(thermal_shutdown) |-> power_good_oe)
        else $error("pg released hot");
    a_pg_open_drain: assert property (power_good_oe |-> !power_good_out)
        else $error("pg data high");
    a_disable_all: assert property ($fell(enable_lockout_input) |-> ##4 (power_good_oe
        && !soft_start_enable && !high_side_gate && !low_side_gate && !hiccup_active))
        else $error("disable incomplete");
    a_prebias_wait: assert property ($rose(high_side_gate) |-> $past(soft_start_above_feedback, 3))
        else $error("switched before crossing");
    a_thermal_off: assert property (thermal_shutdown |-> !high_side_gate && !low_side_gate
        && !soft_start_enable)
        else $error("active in shutdown");
    a_light_load_ls: assert property ($rose(zero_current_detect) && light_load_skip_mode
        |-> ##4 !low_side_gate)
        else $error("low side after zero");
endmodule

bind cfs_sequencer cfs_monitor #(
    .HICCUP_CYCLES(HICCUP_CYCLES),
    .PGOOD_DELAY_CYCLES(PGOOD_DELAY_CYCLES)
) u_monitor (.*);
`default_nettype wire

// ==== cfs_plant.sv ====
// Behavioural power stage: oscillator, error-amp peak and zero-current flags.
// Assumes the gate outputs of the sequencer and the system clock.
`timescale 1ns/100ps
`default_nettype none
module cfs_plant #(
    parameter int OSC_HALF = 20,
    parameter int PEAK_CYC = 14,
    parameter int ZC_CYC = 8
) (
    // Clock
    input wire logic clk,
    // Gates from the sequencer
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    // Flags back to the sequencer
    output logic osc_clk_in,
    output logic pwm_peak_reached,
    output logic zero_current_detect
);
    int osc_cnt = 0;
    int hs_cnt = 0;
    int ls_cnt = 0;

    // Free-running oscillator; inductor flags follow the gate times
    always @(posedge clk) begin
        #1;
        osc_cnt = (osc_cnt + 1) % (2 * OSC_HALF);
        osc_clk_in = osc_cnt < OSC_HALF;
        hs_cnt = high_side_gate ? hs_cnt + 1 : 0;
        // Zero current holds until the next pulse
        ls_cnt = low_side_gate ? ls_cnt + 1 : (high_side_gate ? 0 : ls_cnt);
        pwm_peak_reached = hs_cnt >= PEAK_CYC;
        zero_current_detect = ls_cnt >= ZC_CYC;
    end
endmodule
`default_nettype wire

// ==== test_converter_fault_sequencer.sv ====
// Self-checking bench of the fault sequencer and stage model.
// Assumes counts shortened to 4 and a 40-clock oscillator.
`timescale 1ns/100ps
`default_nettype none
module test_converter_fault_sequencer;
    localparam int OSC = 40;
    typedef struct packed {logic en, uv, hot, cool, thm, ss, oe;} cfs_row_t;
    cfs_row_t rows [6] = '{7'b0000001, 7'b1000011, 7'b1100001, 7'b1010101, 7'b1000101, 7'b1001011};
    logic clk = 1'b0, rst_n = 1'b0, enable_lockout_input = 1'b0, vcc_undervoltage = 1'b0;
    logic cycle_current_limit = 1'b0, severe_overcurrent_limit = 1'b0, feedback_below_hiccup = 1'b1;
    logic soft_start_above_feedback = 1'b0, soft_start_done = 1'b0, output_above_95 = 1'b0;
    logic output_below_92 = 1'b0, thermal_overtemp = 1'b0, thermal_cooled = 1'b0, light_load_skip_mode = 1'b0;
    logic osc_clk_in, pwm_peak_reached, zero_current_detect, high_side_gate, low_side_gate;
    logic soft_start_enable, power_good_out, power_good_oe, hiccup_active, half_freq_active, thermal_shutdown;
    int n_errors = 0;
    int n_tests = 0;
    int k, w, t;

    cfs_sequencer #(.HICCUP_CYCLES(4), .SS_EXTRA_CYCLES(4), .PGOOD_DELAY_CYCLES(4)) i_dut (.*);
    cfs_plant #(.OSC_HALF(OSC / 2)) i_plant (.*);

    // 125 MHz clock
    always #4 clk = ~clk;

    // ********************************
    // Tasks
    // ********************************
    // Inputs move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [2:0] got, input logic [2:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t value %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_in(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int took);
        took = 0;
        while (s !== v) begin
            if (took == lim) begin
                n_errors++;
                $display("[ERR] %0t wait ran out", $time);
                results();
            end
            step(1);
            took++;
        end
    endtask
    // High-side rises and last pulse width
    task automatic watch(input int cyc, output int rises, output int width);
        logic prev;
        int cur;
        rises = 0;
        width = 0;
        cur = 0;
        repeat (cyc) begin
            prev = high_side_gate;
            step(1);
            rises += int'(high_side_gate && !prev);
            if (!high_side_gate && prev)
                width = cur;
            cur = high_side_gate ? cur + 1 : 0;
        end
    endtask
    task automatic results;
        $display("TB: tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        step(2);
        rst_n = 1'b1;
        // Supply and thermal rows
        foreach (rows[i]) begin
            {enable_lockout_input, vcc_undervoltage, thermal_overtemp, thermal_cooled} = rows[i][6:3];
            step(12);
            check({thermal_shutdown, soft_start_enable, power_good_oe}, rows[i][2:0]);
            check({high_side_gate, 2'b00}, 3'b000);
        end
        thermal_cooled = 1'b0;
        $display("TB: rows done");
        // Startup at half rate, then full rate
        soft_start_above_feedback = 1'b1;
        watch(16 * OSC, k, w);
        check_in(k, 7, 9);
        check({half_freq_active, 2'b00}, 3'b100);
        feedback_below_hiccup = 1'b0;
        watch(4 * OSC, k, w);
        watch(16 * OSC, k, w);
        check_in(k, 15, 17);
        check({half_freq_active, 2'b00}, 3'b000);
        // Peak limit cuts to the on-time floor
        cycle_current_limit = 1'b1;
        watch(4 * OSC, k, w);
        check_in(w, 10, 12);
        cycle_current_limit = 1'b0;
        $display("TB: switching done");
        // Power-good delay restarts after a dip
        output_above_95 = 1'b1;
        step(2 * OSC);
        output_below_92 = 1'b1;
        step(10);
        check({power_good_oe, power_good_out, 1'b0}, 3'b100);
        output_below_92 = 1'b0;
        for (t = 0; power_good_oe !== 1'b0; t++) begin
            step(1);
            if (t == 20 * OSC) begin
                n_errors++;
                $display("[ERR] %0t pg wait ran out", $time);
                results();
            end
        end
        check_in(t, 3 * OSC, 5 * OSC + 8);
        $display("TB: power-good done");
        // Severe overcurrent, hiccup, fresh soft-start
        severe_overcurrent_limit = 1'b1;
        step(3);
        severe_overcurrent_limit = 1'b0;
        wait_lvl(hiccup_active, 1'b1, 10, t);
        check({high_side_gate, low_side_gate, 1'b0}, 3'b000);
        wait_lvl(hiccup_active, 1'b0, 3000, t);
        check_in(t, 3 * 2 * OSC, 5 * 2 * OSC + 8);
        check({soft_start_enable, 2'b00}, 3'b100);
        // Feedback loss after soft-start
        soft_start_done = 1'b1;
        step(4 * OSC);
        feedback_below_hiccup = 1'b1;
        wait_lvl(hiccup_active, 1'b1, 10, t);
        wait_lvl(hiccup_active, 1'b0, 3000, t);
        // Feedback never up: extension, then hiccup
        step(2 * OSC);
        check({half_freq_active, 2'b00}, 3'b100);
        wait_lvl(hiccup_active, 1'b1, 3000, t);
        check_in(t + 2 * OSC, 3 * 2 * OSC, 5 * 2 * OSC + 16);
        $display("TB: hiccup done");
        // Disable mid-hiccup, restart in light-load mode
        enable_lockout_input = 1'b0;
        step(8);
        check({power_good_oe, hiccup_active, soft_start_enable}, 3'b100);
        feedback_below_hiccup = 1'b0;
        soft_start_done = 1'b0;
        light_load_skip_mode = 1'b1;
        enable_lockout_input = 1'b1;
        // A pulse first clears the zero flag held from before
        wait_lvl(high_side_gate, 1'b1, 8 * OSC, t);
        wait_lvl(zero_current_detect, 1'b1, 4 * OSC, t);
        step(4);
        check({low_side_gate, 2'b00}, 3'b000);
        $display("TB: light load done");
        results();
    end
endmodule
`default_nettype wire
